// ### inc/tlfdl_pkg.sv
package tlfdl_pkg;

  // ==========================================================================
  // Register map (printed offsets are not multiples of four: byte addr = 4*idx)
  localparam logic [7:0] IDX_RX_BYTE = 8'hC0;
  localparam logic [7:0] IDX_TX_BYTE = 8'hC1;
  localparam logic [7:0] IDX_MATCH_ONE = 8'hC2;
  localparam logic [7:0] IDX_MATCH_TWO = 8'hC3;
  localparam logic [7:0] IDX_CTRL = 8'hC4;
  localparam logic [7:0] IDX_STATUS = 8'hC5;
  localparam logic [7:0] IDX_MASK = 8'hC6;
  localparam int ADDR_W = 12;

  // ==========================================================================
  // Control bit positions
  localparam int CTRL_DESTUFF = 0;
  localparam int CTRL_STUFF = 1;
  localparam int CTRL_FS_SRC = 2;
  localparam int CTRL_MF_LOAD = 3;
  localparam int CTRL_D4 = 4;

  // Status and mask bit positions
  localparam int ST_MATCH = 1;
  localparam int ST_TX_EMPTY = 2;
  localparam int ST_RX_FULL = 3;

  // ==========================================================================
  // Reset values and counts
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [3:0] FLAG_RST = 4'h0;
  localparam logic [2:0] RUN_STUFF = 3'h5;
  localparam logic [2:0] RUN_SAT = 3'h6;
  localparam logic [2:0] BIT_LAST = 3'h7;

  typedef struct packed {
    logic [7:0] sh;
    logic [2:0] cnt;
    logic [2:0] run;
    logic done;
    logic match;
  } tlfdl_rx_t;

  typedef struct packed {
    logic [7:0] sh;
    logic [2:0] cnt;
    logic [2:0] run;
    logic pend;
    logic done;
  } tlfdl_tx_t;

endpackage : tlfdl_pkg

// ### logic/tlfdl_byte_port.sv
`timescale 1ns/100ps
`default_nettype none
module tlfdl_byte_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input wire logic tx_bit_req,
  input wire logic mf_boundary,
  input wire logic fs_alt_bit,
  output logic tx_bit,
  output logic tx_bit_valid,
  output logic irq_n
);

  // ==========================================================================
  // State
  typedef struct packed {
    tlfdl_pkg::tlfdl_rx_t rx;
    tlfdl_pkg::tlfdl_tx_t tx;
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;
    logic [7:0] m1;
    logic [7:0] m2;
    logic [4:0] ctrl;
    logic [3:0] status;
    logic [3:0] mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic tx_bit;
    logic tx_bit_valid;
    logic irq_n;
  } tlfdl_state_t;

  tlfdl_state_t s_r;
  tlfdl_state_t s_nxt;

  logic [2:0] rx_run_nxt;
  logic rx_five;
  logic [2:0] tx_run_nxt;
  logic tx_five;
  logic tx_cur;

  assign tx_cur = s_r.tx.sh[0];

  // ==========================================================================
  // Ones-run trackers for destuffing and stuffing
  tlfdl_run_counter u_rx_run (
    .run(s_r.rx.run),
    .bit_in(rx_bit),
    .run_nxt(rx_run_nxt),
    .hit_five(rx_five)
  );

  tlfdl_run_counter u_tx_run (
    .run(s_r.tx.run),
    .bit_in(tx_cur),
    .run_nxt(tx_run_nxt),
    .hit_five(tx_five)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    logic acc;
    logic [9:0] idx;
    logic [7:0] wb;
    logic [3:0] set;
    logic [7:0] done_byte;
    logic stuffing;
    logic take_new;
    acc = 1'b0;
    idx = 10'h000;
    wb = 8'h00;
    set = 4'h0;
    done_byte = 8'h00;
    stuffing = 1'b0;
    take_new = 1'b0;
    s_nxt = s_r;
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;
    s_nxt.tx_bit_valid = 1'b0;

    // Receive path
    if (rx_bit_valid) begin
      s_nxt.rx.run = rx_run_nxt;
      if (s_r.ctrl[tlfdl_pkg::CTRL_DESTUFF] && rx_five && !rx_bit) begin
        // Stuffed zero is dropped; run of exactly five only
      end else begin
        done_byte = {rx_bit, s_r.rx.sh[7:1]};
        s_nxt.rx.sh = done_byte;
        s_nxt.rx.cnt = s_r.rx.cnt + 3'h1;
        if (s_r.rx.cnt == tlfdl_pkg::BIT_LAST) begin
          s_nxt.rx_byte = done_byte; // Overwrites unread byte
          set[tlfdl_pkg::ST_RX_FULL] = 1'b1;
          if (done_byte == s_r.m1 || done_byte == s_r.m2) begin
            set[tlfdl_pkg::ST_MATCH] = 1'b1;
          end
        end
      end
    end

    // Transmit path
    if (tx_bit_req) begin
      s_nxt.tx_bit_valid = 1'b1;
      stuffing = s_r.ctrl[tlfdl_pkg::CTRL_STUFF] && !s_r.ctrl[tlfdl_pkg::CTRL_D4];
      if (s_r.ctrl[tlfdl_pkg::CTRL_D4] && s_r.ctrl[tlfdl_pkg::CTRL_FS_SRC]) begin
        s_nxt.tx_bit = fs_alt_bit; // Fs from alternate source
      end else if (stuffing && s_r.tx.run == tlfdl_pkg::RUN_STUFF) begin
        s_nxt.tx_bit = 1'b0;
        s_nxt.tx.run = 3'h0;
      end else begin
        s_nxt.tx_bit = tx_cur;
        s_nxt.tx.run = tx_run_nxt;
        s_nxt.tx.sh = {1'b0, s_r.tx.sh[7:1]};
        s_nxt.tx.cnt = s_r.tx.cnt + 3'h1;
        if (s_r.tx.cnt == tlfdl_pkg::BIT_LAST) begin
          set[tlfdl_pkg::ST_TX_EMPTY] = 1'b1;
          take_new = 1'b1;
        end
      end
    end
    // Multiframe-load: byte reloads only at multiframe boundaries in D4
    if (s_r.ctrl[tlfdl_pkg::CTRL_MF_LOAD] && s_r.ctrl[tlfdl_pkg::CTRL_D4]) begin
      take_new = mf_boundary && (s_r.tx.cnt == 3'h0) && !tx_bit_req;
    end
    if (take_new) begin
      s_nxt.tx.sh = s_r.tx_byte; // Unchanged byte resent
      s_nxt.tx.cnt = 3'h0;
    end

    // APB slave: one wait state, pready answered in the cycle after the first access cycle
    acc = psel && penable && !s_r.pready;
    idx = paddr[11:2];
    wb = pwdata[7:0];
    if (acc) begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = 32'h0000_0000;
      if (idx[9:8] != 2'h0) begin
        s_nxt.pslverr = 1'b1;
      end else begin
        unique case (idx[7:0])
          tlfdl_pkg::IDX_RX_BYTE: begin
            s_nxt.prdata[7:0] = s_r.rx_byte;
            if (pwrite) begin
              s_nxt.pslverr = 1'b1;
            end
          end
          tlfdl_pkg::IDX_TX_BYTE: begin
            s_nxt.prdata[7:0] = s_r.tx_byte;
            if (pwrite && pstrb[0]) begin
              s_nxt.tx_byte = wb;
            end
          end
          tlfdl_pkg::IDX_MATCH_ONE: begin
            s_nxt.prdata[7:0] = s_r.m1;
            if (pwrite && pstrb[0]) begin
              s_nxt.m1 = wb;
            end
          end
          tlfdl_pkg::IDX_MATCH_TWO: begin
            s_nxt.prdata[7:0] = s_r.m2;
            if (pwrite && pstrb[0]) begin
              s_nxt.m2 = wb;
            end
          end
          tlfdl_pkg::IDX_CTRL: begin
            s_nxt.prdata[4:0] = s_r.ctrl;
            if (pwrite && pstrb[0]) begin
              s_nxt.ctrl = wb[4:0];
            end
          end
          tlfdl_pkg::IDX_STATUS: begin
            s_nxt.prdata[3:0] = s_r.status;
            if (pwrite && pstrb[0]) begin
              s_nxt.status = s_r.status & ~wb[3:0];
            end
          end
          tlfdl_pkg::IDX_MASK: begin
            s_nxt.prdata[3:0] = s_r.mask;
            if (pwrite && pstrb[0]) begin
              s_nxt.mask = wb[3:0];
            end
          end
          default: begin
            s_nxt.pslverr = 1'b1;
          end
        endcase
      end
    end

    // Hardware set wins over a same-cycle write-one clear
    s_nxt.status = s_nxt.status | set;
    s_nxt.status[0] = 1'b0;
    s_nxt.irq_n = ~|(s_nxt.status & s_r.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.rx_byte <= tlfdl_pkg::BYTE_RST;
      s_r.tx_byte <= tlfdl_pkg::BYTE_RST;
      s_r.ctrl <= tlfdl_pkg::CTRL_RST;
      s_r.status <= tlfdl_pkg::FLAG_RST;
      s_r.mask <= tlfdl_pkg::FLAG_RST;
      s_r.irq_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Outputs straight from flops
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign tx_bit = s_r.tx_bit;
  assign tx_bit_valid = s_r.tx_bit_valid;
  assign irq_n = s_r.irq_n;

endmodule : tlfdl_byte_port
`default_nettype wire

// ### logic/tlfdl_run_counter.sv
`timescale 1ns/100ps
`default_nettype none
module tlfdl_run_counter (
  input wire logic [2:0] run,
  input wire logic bit_in,
  output logic [2:0] run_nxt,
  output logic hit_five
);
  // Saturates at six so that six-or-more is distinguishable from five
  always_comb begin
    hit_five = (run == tlfdl_pkg::RUN_STUFF);
    if (!bit_in) begin
      run_nxt = 3'h0;
    end else if (run == tlfdl_pkg::RUN_SAT) begin
      run_nxt = run;
    end else begin
      run_nxt = run + 3'h1;
    end
  end
endmodule : tlfdl_run_counter
`default_nettype wire

// ### testbench/tlfdl_byte_port_props.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// Port checks
module tlfdl_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_bit_valid,
  input wire logic tx_bit_req,
  input wire logic tx_bit_valid,
  input wire logic irq_n
);
  logic acc;
  logic wr;
  assign acc = psel && penable && !pready;
  assign wr = psel && penable && pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_wait_a: assert property (acc |=> pready) else $error("ready missing");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
  err_ready_a: assert property (pslverr |-> pready) else $error("lone error");
  ro_write_a: assert property (acc && pwrite && paddr == 12'h300 |=> pslverr)
    else $error("read-only write taken");
  hole_err_a: assert property (acc && paddr == 12'h31C |=> pslverr) else $error("hole taken");
  tx_valid_a:
    assert property (tx_bit_valid == $past(tx_bit_req)) else $error("bit valid off");
  // Flags and irq share one edge; a mask write acts one edge later
  irq_set_a:
    assert property ($fell(irq_n) |-> $past(rx_bit_valid || tx_bit_req)
      || $past(wr) || $past(wr, 2)) else $error("irq without event");
  irq_clear_a:
    assert property ($rose(irq_n) |-> $past(wr) || $past(wr, 2)) else $error("irq dropped");
endmodule : tlfdl_props
`default_nettype wire

// ### testbench/tlfdl_byte_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// Bench top
module tlfdl_byte_port_tb;
  logic pclk, presetn, psel, penable, pwrite, rxv, rxb, treq, mfb, fsa;
  logic pready, pslverr, txb, txv, irq_n, se, mt, stf, eb, mfe, fsm;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, msk;
  logic [7:0] m1, m2, v, treg, rmb = 8'h00, tms = 8'h00;
  int errors = 0, total_checks = 0, cyc = 0, run = 0, rc = 0, tc = 0, trun = 0;
  tlfdl_byte_port u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .rx_bit_valid(rxv), .rx_bit(rxb),
    .tx_bit_req(treq), .mf_boundary(mfb), .fs_alt_bit(fsa), .tx_bit(txb),
    .tx_bit_valid(txv), .irq_n);
  initial begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end
  // Spare Fs input wanders every cycle; boundaries come from the tx task
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    fsa <= 1'($urandom);
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    se = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // ==========
  // Receive model: one bit, byte checks on each fill
  task automatic rx(input logic b, input logic ds);
    @(posedge pclk);
    rxv <= 1'h1;
    rxb <= b;
    @(posedge pclk);
    rxv <= 1'h0;
    if (ds && run == 5 && !b) run = 0;
    else begin
      run = b ? (run == 6 ? 6 : run + 1) : 0;
      rmb = {b, rmb[7:1]};
      rc++;
    end
    if (rc == 8) begin
      rc = 0;
      mt = (rmb == m1) || (rmb == m2);
      apb(1'h0, tlfdl_pkg::IDX_RX_BYTE, 8'h00);
      chk(rd, {24'h000000, rmb}, "rx byte");
      apb(1'h0, tlfdl_pkg::IDX_STATUS, 8'h00);
      chk(rd & 32'hA, {mt, 1'h0} | 32'h8, "rx status");
      chk(irq_n, !(msk[3] | (mt & msk[1])), "rx irq");
      apb(1'h1, tlfdl_pkg::IDX_STATUS, 8'h0E);
    end
  endtask : rx
  // Transmit model: stuffed zeros take no data bit
  task automatic tx(input int n);
    repeat (n) begin
      @(posedge pclk);
      treq <= 1'h1;
      @(posedge pclk);
      treq <= 1'h0;
      mfb <= mfe & 1'($urandom);
      if (fsm) begin
        eb = fsa;
      end else if (stf && trun == 5) begin
        eb = 1'h0;
        trun = 0;
      end else begin
        eb = tms[tc];
        trun = eb ? trun + 1 : 0;
        tc++;
        if (tc == 8) begin
          tc = 0;
          // With multiframe load the emptied shifter sends zeros until a boundary
          tms = mfe ? 8'h00 : treg;
        end
      end
      @(posedge pclk);
      chk({txv, txb}, {1'h1, eb}, "tx bit");
      if (mfe && mfb && tc == 0) tms = treg;
      mfb <= 1'h0;
    end
  endtask : tx
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  initial begin
    rd = $urandom(32'hE6BC2D5C);
    {presetn, psel, penable, pwrite, rxv, rxb, treq, mfb, stf, mfe, fsm} = '0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    m1 = 8'($urandom);
    m2 = 8'($urandom);
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      apb(1'h0, tlfdl_pkg::IDX_RX_BYTE + 8'(i), 8'h00);
      chk(rd, 32'h00000000, "reset value");
    end
    apb(1'h1, tlfdl_pkg::IDX_MATCH_ONE, m1);
    apb(1'h1, tlfdl_pkg::IDX_MATCH_TWO, m2);
    // Both match bytes, then plain bytes; last one masked
    for (int i = 0; i < 4; i++) begin
      msk = (i == 3) ? 4'h0 : 4'hE;
      apb(1'h1, tlfdl_pkg::IDX_MASK, {4'h0, msk});
      v = (i == 0) ? m1 : (i == 1) ? m2 : 8'($urandom) & 8'h7F;
      for (int j = 0; j < 8; j++) rx(v[j], 1'h0);
    end
    apb(1'h1, tlfdl_pkg::IDX_CTRL, 8'h01);
    v = 8'h00;
    for (int j = 0; j < 17; j++) rx(1'(17'h17E5F >> j), 1'h1);
    for (int j = 0; j < 24 || rc != 0; j++) rx(1'($urandom), 1'h1);
    stf = 1'h1;
    treg = 8'hFF;
    apb(1'h1, tlfdl_pkg::IDX_CTRL, 8'h02);
    apb(1'h1, tlfdl_pkg::IDX_TX_BYTE, treg);
    apb(1'h1, tlfdl_pkg::IDX_MASK, 8'h04);
    tx(20);
    apb(1'h0, tlfdl_pkg::IDX_STATUS, 8'h00);
    chk({rd[2], irq_n}, 2'h2, "tx empty");
    treg = 8'($urandom);
    apb(1'h1, tlfdl_pkg::IDX_TX_BYTE, treg);
    apb(1'h0, tlfdl_pkg::IDX_TX_BYTE, 8'h00);
    chk(rd, {24'h000000, treg}, "tx rw");
    tx(12);
    // D4 keeps stuffing idle even with its enable set
    stf = 1'h0;
    mfe = 1'h1;
    treg = 8'h1C;
    apb(1'h1, tlfdl_pkg::IDX_CTRL, 8'h1A);
    apb(1'h1, tlfdl_pkg::IDX_TX_BYTE, treg);
    tx(20);
    // Alternate Fs source: shifter holds still, spare input goes out
    mfe = 1'h0;
    fsm = 1'h1;
    apb(1'h1, tlfdl_pkg::IDX_CTRL, 8'h14);
    tx(8);
    apb(1'h0, 8'hC7, 8'h00);
    chk(se, 1'h1, "hole");
    apb(1'h1, tlfdl_pkg::IDX_RX_BYTE, 8'h5A);
    chk(se, 1'h1, "ro write");
    end_sim();
  end
endmodule : tlfdl_byte_port_tb
bind tlfdl_byte_port tlfdl_props u_props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pready, .pslverr, .rx_bit_valid, .tx_bit_req, .tx_bit_valid, .irq_n);
`default_nettype wire
